/* File: test/mpps_contacts_model.sv */
// Host-side model of the preset selector contacts
// Assumes the bench names the wanted code; the contacts follow one clock later
module mpps_contacts_model (
  input wire logic aclk,
  input wire logic [2:0] code,
  output logic preset_sel_bit0,
  output logic preset_sel_bit1,
  output logic preset_sel_bit2
);
  timeunit 1ns;
  timeprecision 1ns;
  // All contacts open at power-up, so code 000 is seen
  initial {preset_sel_bit2, preset_sel_bit1, preset_sel_bit0} = 3'h0;
  // Closed contact is 1, open is 0; code bit 2 drives the most significant contact
  always @(posedge aclk) begin
    {preset_sel_bit2, preset_sel_bit1, preset_sel_bit0} <= code;
  end
endmodule // mpps_contacts_model

/* File: test/mpps_sequencer_sva.sv */
// Checker of the sequencer bus handshakes, trigger, mode gate and battery flag
// Assumes one clock and a master that offers write address and data together
module mpps_sequencer_sva #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic battery_protect_en,
  input wire logic move_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ctrl_wr;
  assign ctrl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr == 12'h000 && s_axi_wstrb[1:0] == 2'h3;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  trigger_start_a: assert property (
    ctrl_wr && s_axi_wdata[8] && s_axi_wdata[3:0] == 4'h5 && !move_busy |-> ##[1:5] move_busy)
    else $error("trigger did not start a move");
  mode_gate_a: assert property (
    ctrl_wr && s_axi_wdata[3:0] != 4'h5 && !move_busy |=> !move_busy [*6])
    else $error("move outside internal position mode");
  battery_flag_a: assert property (
    ctrl_wr |-> ##4 (battery_protect_en == !$past(s_axi_wdata[9], 4)))
    else $error("battery flag wrong");
endmodule // mpps_sequencer_sva
bind mpps_sequencer mpps_sequencer_sva #(.TICK_CYCLES(TICK_CYCLES)) u_mpps_sequencer_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .battery_protect_en(battery_protect_en), .move_busy(move_busy));

/* File: test/testbench.sv */
// Self-checking bench of the preset sequencer through its register bus and contacts
// Assumes a shortened tick of 4 clocks per interval unit
`define CHK(got, exp, nm) \
  begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sel0, sel1, sel2, batt, busy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb, strb;
  logic [1:0] bresp, rresp, last_resp;
  logic [2:0] code;
  logic [15:0] acc, dec, acc_seen;
  mpps_pkg::mpps_pos_t enc_pos, cmd_pos, pos;
  int errors, samples_checked, run_len;
  mpps_contacts_model u_mpps_contacts_model (.aclk(aclk), .code(code),
    .preset_sel_bit0(sel0), .preset_sel_bit1(sel1), .preset_sel_bit2(sel2));
  mpps_sequencer #(.TICK_CYCLES(4)) u_mpps_sequencer (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .preset_sel_bit0(sel0), .preset_sel_bit1(sel1), .preset_sel_bit2(sel2),
    .encoder_abs_position(enc_pos), .command_position(cmd_pos), .active_accel_ms(acc),
    .active_decel_ms(dec), .battery_protect_en(batt), .move_busy(busy));
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    bready <= 1'h0;
    last_resp = bresp;
    if (n >= 100) errors++;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    rready <= 1'h0;
    d = rdata;
    last_resp = rresp;
    if (n >= 100) errors++;
    @(posedge aclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(d, e, "register")
  endtask
  // Selector settles through the contacts before the trigger is written
  task automatic go(input logic [2:0] c, input logic [31:0] ctl);
    int n;
    code <= c;
    repeat (2) @(posedge aclk);
    wr(12'h000, ctl);
    for (n = 0; busy !== 1'h1 && n < 10; n++) @(posedge aclk);
    acc_seen = acc;
    for (run_len = 0; busy === 1'h1 && run_len < 5000; run_len++) @(posedge aclk);
    @(posedge aclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always #5 aclk = ~aclk;
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    report_and_stop();
  end
  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr} = 24'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    strb = 4'hF;
    code = 3'h0;
    enc_pos = 32'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rchk(12'h008, 32'h20);
    rchk(12'h00C, 32'h0);
    rd(12'hFFC, v);
    `CHK(last_resp, 2'h2, "unmapped rresp")
    wr(12'hFFC, 32'h0);
    `CHK(last_resp, 2'h2, "unmapped bresp")
    for (int i = 0; i < 8; i++) begin
      rchk(12'h0A0 + 12'(i * 4), 32'h64);
      rchk(12'h0C0 + 12'(i * 4), 32'h64);
      wr(12'h040 + 12'(i * 4), 32'((i + 1) * 256));
      wr(12'h060 + 12'(i * 4), 32'((i + 1) * 16));
      wr(12'h0A0 + 12'(i * 4), 32'(16 + i));
      wr(12'h0C0 + 12'(i * 4), 32'(32 + i));
    end
    strb = 4'h1;
    wr(12'h0A0, 32'h1234);
    strb = 4'hF;
    rchk(12'h0A0, 32'h34);
    wr(12'h0A0, 32'h10);
    $display("test reset values done");
    wr(12'h000, 32'h301);
    repeat (8) @(posedge aclk);
    `CHK(busy, 1'h0, "busy")
    `CHK(cmd_pos, 32'h0, "idle position")
    $display("test mode gate done");
    wr(12'h004, 32'h0);
    pos = 32'h0;
    for (int c = 0; c < 8; c++) begin
      go(3'(c), 32'h305);
      pos = pos + 32'((c + 1) * 256);
      `CHK(cmd_pos, pos, "position")
      `CHK(acc_seen, 16'(16 + c), "accel")
      `CHK(dec, 16'(32 + c), "decel")
      `CHK(run_len >= 16 && run_len <= 24, 1'h1, "move time")
    end
    rchk(12'h000, 32'h205);
    `CHK(batt, 1'h0, "battery")
    $display("test presets done");
    wr(12'h004, 32'h1);
    go(3'h2, 32'h305);
    `CHK(cmd_pos, 32'h300, "abs position")
    go(3'h2, 32'h305);
    `CHK(cmd_pos, 32'h300, "abs repeat")
    enc_pos <= 32'h1000;
    wr(12'h000, 32'h5);
    repeat (4) @(posedge aclk);
    `CHK(batt, 1'h1, "battery")
    go(3'h1, 32'h105);
    `CHK(cmd_pos, 32'h1200, "encoder position")
    $display("test absolute done");
    wr(12'h004, 32'h0);
    wr(12'h080, 32'h0);
    wr(12'h084, 32'hA);
    wr(12'h088, 32'h1);
    wr(12'h008, 32'h31);
    wr(12'h00C, 32'h2);
    pos = cmd_pos;
    go(3'h7, 32'h305);
    `CHK(cmd_pos, pos + 32'hC00, "auto position")
    `CHK(run_len >= 80, 1'h1, "auto wait")
    `CHK(run_len <= 300, 1'h1, "auto time")
    rd(12'h010, v);
    `CHK(v[31:16], 16'h2, "cycles done")
    $display("test auto run done");
    wr(12'h00C, 32'h0);
    wr(12'h000, 32'h305);
    repeat (500) @(posedge aclk);
    `CHK(busy, 1'h1, "endless run")
    rd(12'h010, v);
    `CHK(v[31:16] >= 16'h2, 1'h1, "endless cycles")
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK(busy, 1'h0, "busy after reset")
    rchk(12'h008, 32'h20);
    $display("test endless run done");
    report_and_stop();
  end
endmodule // testbench

/* File: verilog/mpps_executor.sv */
// Motion executor: steps the commanded position toward the goal at the preset speed
// Assumes start is a pulse and goal stays stable while a move runs
module mpps_executor
  import mpps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  mpps_move_if.exe mv,
  output mpps_pos_t position
);
  typedef struct packed {
    mpps_pos_t pos;
    mpps_pos_t goal;
    logic busy;
    logic done;
  } mpps_exe_s;
  mpps_exe_s st_reg, st_next;
  mpps_pos_t diff;
  mpps_pos_t step;
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    diff = st_reg.goal - st_reg.pos;
    step = (mv.speed == 16'h0000) ? 32'sh1 : mpps_pos_t'({16'h0000, mv.speed});
    if (mv.start) begin
      st_next.goal = mv.goal;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (diff > step) begin
        st_next.pos = st_reg.pos + step;
      end else if (diff < -step) begin
        st_next.pos = st_reg.pos - step;
      end else begin
        st_next.pos = st_reg.goal;
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign mv.done = st_reg.done;
  assign position = st_reg.pos;
endmodule // mpps_executor

/* File: verilog/mpps_interval.sv */
// Interval timer counting stage wait time in millisecond ticks
// Assumes load is a pulse; a zero count finishes at once
module mpps_interval #(
  parameter int TICK_CYCLES = 100000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [15:0] count,
  output logic expired
);
  typedef struct packed {
    logic [16:0] tick;
    logic [15:0] left;
    logic run;
    logic expired;
  } mpps_tmr_s;
  mpps_tmr_s st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.expired = 1'b0;
    if (load) begin
      st_next.left = count;
      st_next.tick = '0;
      st_next.run = (count != 16'h0000);
      st_next.expired = (count == 16'h0000);
    end else if (st_reg.run) begin
      if (st_reg.tick == 17'(TICK_CYCLES - 1)) begin
        st_next.tick = '0;
        st_next.left = st_reg.left - 16'h0001;
        if (st_reg.left == 16'h0001) begin
          st_next.run = 1'b0;
          st_next.expired = 1'b1;
        end
      end else begin
        st_next.tick = st_reg.tick + 17'h00001;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign expired = st_reg.expired;
endmodule // mpps_interval

/* File: verilog/mpps_map.svh */
// Register offsets, field positions, reset values and timing counts of the preset sequencer
// Assumes inclusion by the package and the top module only
`ifndef MPPS_MAP_SVH
`define MPPS_MAP_SVH
`define MPPS_OFF_CTRL 12'h000
`define MPPS_OFF_MOVE_TYPE 12'h004
`define MPPS_OFF_MULTISTAGE 12'h008
`define MPPS_OFF_CYCLE 12'h00C
`define MPPS_OFF_STATUS 12'h010
`define MPPS_OFF_POSITION 12'h014
`define MPPS_OFF_TARGET_BASE 12'h040
`define MPPS_OFF_SPEED_BASE 12'h060
`define MPPS_OFF_INTERVAL_BASE 12'h080
`define MPPS_OFF_ACCEL_BASE 12'h0A0
`define MPPS_OFF_DECEL_BASE 12'h0C0
`define MPPS_CTRL_MODE_LSB 0
`define MPPS_CTRL_TRIGGER_BIT 8
`define MPPS_CTRL_ENC_REF_BIT 9
`define MPPS_MODE_INTERNAL 4'h5
`define MPPS_MS_ENABLE_LSB 0
`define MPPS_MS_STAGES_LSB 4
`define MPPS_MULTISTAGE_RESET 16'h0020
`define MPPS_CYCLE_RESET 16'h0000
`define MPPS_RAMP_RESET 16'h0064
`define MPPS_MS_PER_UNIT 1
`define MPPS_CLK_MHZ 100
`define MPPS_TICK_CYCLES (`MPPS_MS_PER_UNIT * `MPPS_CLK_MHZ * 1000)
`endif

/* File: verilog/mpps_move_if.sv */
// Move request and completion between the sequencer and the motion executor
// Assumes one clock shared by both ends
interface mpps_move_if;
  import mpps_pkg::*;
  logic start;
  logic done;
  mpps_pos_t goal;
  logic [15:0] speed;
  modport seq (output start, output goal, output speed, input done);
  modport exe (input start, input goal, input speed, output done);
endinterface

/* File: verilog/mpps_pkg.sv */
// Types shared by the preset sequencer modules
// Assumes nothing beyond the map header
package mpps_pkg;
  typedef enum logic [2:0] {
    MPPS_IDLE = 3'h0,
    MPPS_MOVE = 3'h1,
    MPPS_WAIT = 3'h3,
    MPPS_NEXT = 3'h2
  } mpps_state_e;
  typedef logic [2:0] mpps_idx_t;
  typedef logic signed [31:0] mpps_pos_t;
endpackage

/* File: verilog/mpps_sequencer.sv */
// Multistage preset position sequencer with AXI4-Lite parameter registers
// Assumes selector contacts are synchronous to aclk; one write and one read at a time
// Functional notes
// - Eight presets; selector code, bit2 most significant, 000 picks preset 1.
// - Each preset has a target and a speed used for its move.
// - Undriven selector reads 000, so preset 1 by default.
// - Open contact is 0, closed contact is 1; host closes contacts.
// - Multistage enable 0 disables automatic run; 1 runs presets in sequence.
// - Between stages wait the interval belonging to that stage.
// - Interval of zero moves straight to the next preset without waiting.
// - Repeat sequence cycle_count times; zero repeats forever.
// - Internal position mode only when control mode equals five.
// - Move type 0 is incremental, 1 is absolute.
// - Incremental moves accumulate; absolute moves end at stated coordinate.
// - Encoder reference 1 blocks battery protection and absolute encoder feedback.
// - Encoder reference 0 uses encoder absolute feedback for absolute moves.
// - Each preset keeps displacement, speed, accel and decel times.
// - Writing trigger 1 starts a move; the bit clears itself.
`include "mpps_map.svh"
module mpps_sequencer #(
  parameter int TICK_CYCLES = `MPPS_TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic preset_sel_bit0,
  input wire logic preset_sel_bit1,
  input wire logic preset_sel_bit2,
  input wire mpps_pkg::mpps_pos_t encoder_abs_position,
  output mpps_pkg::mpps_pos_t command_position,
  output logic [15:0] active_accel_ms,
  output logic [15:0] active_decel_ms,
  output logic battery_protect_en,
  output logic move_busy
);
  import mpps_pkg::*;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] control_mode_select;
    logic internal_move_trigger;
    logic enc_ref_sel;
    logic [15:0] move_type_select;
    logic [15:0] multistage_setting;
    logic [15:0] cycle_count;
    mpps_state_e state;
    mpps_idx_t stage;
    logic [15:0] cycles_done;
    logic auto_run;
    mpps_pos_t base;
    logic mv_start;
    mpps_pos_t mv_goal;
    logic [15:0] mv_speed;
    logic tmr_load;
    logic [15:0] tmr_count;
    mpps_pos_t cmd_pos;
    logic [15:0] accel;
    logic [15:0] decel;
    logic batt;
    logic busy;
  } mpps_top_s;
  mpps_top_s st_reg, st_next;
  mpps_pos_t preset_target_reg [8];
  logic [15:0] preset_speed_reg [8];
  logic [15:0] stage_interval_reg [8];
  logic [15:0] accel_reg [8];
  logic [15:0] decel_reg [8];
  mpps_move_if mv ();
  mpps_pos_t exe_pos;
  logic tmr_expired;
  logic wr_fire;
  mpps_idx_t sel_code;
  mpps_idx_t last_stage;
  logic mode_ok;
  function automatic logic in_table(input logic [11:0] a, input logic [11:0] base);
    in_table = (a >= base) && (a < base + 12'h020) && (a[1:0] == 2'b00);
  endfunction
  function automatic mpps_idx_t tbl_idx(input logic [11:0] a);
    tbl_idx = a[4:2];
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
  mpps_executor u_exe (
    .aclk(aclk),
    .aresetn(aresetn),
    .mv(mv.exe),
    .position(exe_pos)
  );
  mpps_interval #(.TICK_CYCLES(TICK_CYCLES)) u_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(st_reg.tmr_load),
    .count(st_reg.tmr_count),
    .expired(tmr_expired)
  );
  assign mv.start = st_reg.mv_start;
  assign mv.goal = st_reg.mv_goal;
  assign mv.speed = st_reg.mv_speed;
  assign wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  // Open contacts read 0, so an unwired selector gives code 000
  assign sel_code = {preset_sel_bit2, preset_sel_bit1, preset_sel_bit0};
  assign mode_ok = (st_reg.control_mode_select == `MPPS_MODE_INTERNAL);
  // Stage field below two still runs one stage; above eight is clipped to eight
  assign last_stage = (st_reg.multistage_setting[`MPPS_MS_STAGES_LSB +: 4] == 4'h0) ? 3'h0 :
                      (st_reg.multistage_setting[`MPPS_MS_STAGES_LSB +: 4] > 4'h8) ? 3'h7 :
                      3'(st_reg.multistage_setting[`MPPS_MS_STAGES_LSB +: 4] - 4'h1);
  always_comb begin
    mpps_idx_t p;
    logic [11:0] ra;
    p = '0;
    ra = s_axi_araddr;
    st_next = st_reg;
    st_next.mv_start = 1'b0;
    st_next.tmr_load = 1'b0;
    st_next.internal_move_trigger = 1'b0;
    // Write channels taken independently, answered once both are in
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.w_data = merge(32'h00000000, s_axi_wdata, s_axi_wstrb);
      st_next.wready = 1'b0;
    end
    if (wr_fire) begin
      st_next.bvalid = 1'b1;
      st_next.bresp = 2'b00;
      unique case (st_reg.aw_addr)
        `MPPS_OFF_CTRL: begin
          st_next.control_mode_select = st_reg.w_data[`MPPS_CTRL_MODE_LSB +: 4];
          st_next.internal_move_trigger = st_reg.w_data[`MPPS_CTRL_TRIGGER_BIT];
          st_next.enc_ref_sel = st_reg.w_data[`MPPS_CTRL_ENC_REF_BIT];
        end
        `MPPS_OFF_MOVE_TYPE: st_next.move_type_select = st_reg.w_data[15:0];
        `MPPS_OFF_MULTISTAGE: st_next.multistage_setting = st_reg.w_data[15:0];
        `MPPS_OFF_CYCLE: st_next.cycle_count = st_reg.w_data[15:0];
        default: begin
          if (!(in_table(st_reg.aw_addr, `MPPS_OFF_TARGET_BASE) ||
                in_table(st_reg.aw_addr, `MPPS_OFF_SPEED_BASE) ||
                in_table(st_reg.aw_addr, `MPPS_OFF_INTERVAL_BASE) ||
                in_table(st_reg.aw_addr, `MPPS_OFF_ACCEL_BASE) ||
                in_table(st_reg.aw_addr, `MPPS_OFF_DECEL_BASE))) begin
            st_next.bresp = 2'b10;
          end
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end
    // Read: one cycle to rvalid, arready low while data waits
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = 2'b00;
      st_next.rdata = 32'h00000000;
      unique case (ra)
        `MPPS_OFF_CTRL: st_next.rdata = {22'h000000, st_reg.enc_ref_sel, 5'h00,
                                         st_reg.control_mode_select};
        `MPPS_OFF_MOVE_TYPE: st_next.rdata = {16'h0000, st_reg.move_type_select};
        `MPPS_OFF_MULTISTAGE: st_next.rdata = {16'h0000, st_reg.multistage_setting};
        `MPPS_OFF_CYCLE: st_next.rdata = {16'h0000, st_reg.cycle_count};
        `MPPS_OFF_STATUS: st_next.rdata = {st_reg.cycles_done, 8'h00, 2'b00, st_reg.stage,
                                           st_reg.auto_run, st_reg.busy, st_reg.state[0]};
        `MPPS_OFF_POSITION: st_next.rdata = st_reg.cmd_pos;
        default: begin
          if (in_table(ra, `MPPS_OFF_TARGET_BASE)) begin
            st_next.rdata = preset_target_reg[tbl_idx(ra)];
          end else if (in_table(ra, `MPPS_OFF_SPEED_BASE)) begin
            st_next.rdata = {16'h0000, preset_speed_reg[tbl_idx(ra)]};
          end else if (in_table(ra, `MPPS_OFF_INTERVAL_BASE)) begin
            st_next.rdata = {16'h0000, stage_interval_reg[tbl_idx(ra)]};
          end else if (in_table(ra, `MPPS_OFF_ACCEL_BASE)) begin
            st_next.rdata = {16'h0000, accel_reg[tbl_idx(ra)]};
          end else if (in_table(ra, `MPPS_OFF_DECEL_BASE)) begin
            st_next.rdata = {16'h0000, decel_reg[tbl_idx(ra)]};
          end else begin
            st_next.rresp = 2'b10;
          end
        end
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
    // Sequencer
    unique case (st_reg.state)
      MPPS_IDLE: begin
        if (st_reg.internal_move_trigger && mode_ok) begin
          st_next.auto_run = st_reg.multistage_setting[`MPPS_MS_ENABLE_LSB];
          p = st_reg.multistage_setting[`MPPS_MS_ENABLE_LSB] ? 3'h0 : sel_code;
          st_next.stage = p;
          st_next.cycles_done = 16'h0000;
          st_next.state = MPPS_MOVE;
          st_next.mv_start = 1'b1;
        end
      end
      MPPS_MOVE: begin
        if (mv.done) begin
          st_next.base = exe_pos;
          if (!st_reg.auto_run || !mode_ok) begin
            st_next.state = MPPS_IDLE;
          end else begin
            st_next.tmr_load = 1'b1;
            st_next.tmr_count = stage_interval_reg[st_reg.stage];
            st_next.state = MPPS_WAIT;
          end
        end
      end
      MPPS_WAIT: if (tmr_expired) st_next.state = MPPS_NEXT;
      MPPS_NEXT: begin
        st_next.state = MPPS_MOVE;
        st_next.mv_start = 1'b1;
        if (st_reg.stage >= last_stage) begin
          st_next.stage = 3'h0;
          st_next.cycles_done = st_reg.cycles_done + 16'h0001;
          if (st_reg.cycle_count != 16'h0000 &&
              st_reg.cycles_done + 16'h0001 >= st_reg.cycle_count) begin
            st_next.state = MPPS_IDLE;
            st_next.mv_start = 1'b0;
            st_next.auto_run = 1'b0;
          end
        end else begin
          st_next.stage = st_reg.stage + 3'h1;
        end
      end
    endcase
    // Goal and profile of the stage about to move
    if (st_next.mv_start) begin
      p = st_next.stage;
      st_next.mv_speed = preset_speed_reg[p];
      st_next.accel = accel_reg[p];
      st_next.decel = decel_reg[p];
      if (st_reg.move_type_select[0]) begin
        // Reference 0 measures absolute targets from the encoder's absolute position
        st_next.mv_goal = preset_target_reg[p] +
          (st_reg.enc_ref_sel ? 32'sh0 : encoder_abs_position);
      end else begin
        st_next.mv_goal = st_reg.base + preset_target_reg[p];
      end
    end
    st_next.batt = !st_reg.enc_ref_sel;
    st_next.cmd_pos = exe_pos;
    st_next.busy = (st_reg.state != MPPS_IDLE);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.multistage_setting <= `MPPS_MULTISTAGE_RESET;
      st_reg.cycle_count <= `MPPS_CYCLE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end
  // Table writes kept outside the struct; reset loads ramps with their default and the other arrays with zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        accel_reg[i] <= `MPPS_RAMP_RESET;
        decel_reg[i] <= `MPPS_RAMP_RESET;
        preset_target_reg[i] <= '0;
        preset_speed_reg[i] <= '0;
        stage_interval_reg[i] <= '0;
      end
    end else if (wr_fire) begin
      if (in_table(st_reg.aw_addr, `MPPS_OFF_TARGET_BASE)) begin
        preset_target_reg[tbl_idx(st_reg.aw_addr)] <= st_reg.w_data;
      end
      if (in_table(st_reg.aw_addr, `MPPS_OFF_SPEED_BASE)) begin
        preset_speed_reg[tbl_idx(st_reg.aw_addr)] <= st_reg.w_data[15:0];
      end
      if (in_table(st_reg.aw_addr, `MPPS_OFF_INTERVAL_BASE)) begin
        stage_interval_reg[tbl_idx(st_reg.aw_addr)] <= st_reg.w_data[15:0];
      end
      if (in_table(st_reg.aw_addr, `MPPS_OFF_ACCEL_BASE)) begin
        accel_reg[tbl_idx(st_reg.aw_addr)] <= st_reg.w_data[15:0];
      end
      if (in_table(st_reg.aw_addr, `MPPS_OFF_DECEL_BASE)) begin
        decel_reg[tbl_idx(st_reg.aw_addr)] <= st_reg.w_data[15:0];
      end
    end
  end
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign command_position = st_reg.cmd_pos;
  assign active_accel_ms = st_reg.accel;
  assign active_decel_ms = st_reg.decel;
  assign battery_protect_en = st_reg.batt;
  assign move_busy = st_reg.busy;
endmodule // mpps_sequencer
